// ==== include/hic_pkg.sv ====
// constants and types for the haptic input interpretation control block
`default_nettype none
package hic_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] HIC_CTRL_ADDR  = 8'h1C;
	localparam logic [7:0] HIC_STAT_ADDR  = 8'h1D;
	localparam logic [7:0] HIC_CTRL_RST   = 8'hDA;
	localparam int         HIC_BIDIR_BIT  = 7;
	localparam int         HIC_STAB_BIT   = 6;
	localparam int         HIC_SAMP_LSB   = 4;
	localparam int         HIC_STAT_BRAKE = 0;
	localparam int         HIC_STAT_GAIN  = 1;
	localparam int         HIC_STAT_CLOSE = 2;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int HIC_CLK_MHZ    = 125;
	localparam int HIC_SAMP0_US   = 150;
	localparam int HIC_SAMP1_US   = 200;
	localparam int HIC_SAMP2_US   = 250;
	localparam int HIC_SAMP3_US   = 300;
	localparam int HIC_SAMP0_CYC  = HIC_SAMP0_US * HIC_CLK_MHZ;
	localparam int HIC_SAMP1_CYC  = HIC_SAMP1_US * HIC_CLK_MHZ;
	localparam int HIC_SAMP2_CYC  = HIC_SAMP2_US * HIC_CLK_MHZ;
	localparam int HIC_SAMP3_CYC  = HIC_SAMP3_US * HIC_CLK_MHZ;
	localparam int HIC_AMP_W      = 8;
	localparam int HIC_CNT_W      = 16;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HIC_MODE_UNI    = 2'b00,
		HIC_MODE_BIOPEN = 2'b01,
		HIC_MODE_BICLO  = 2'b10
	} hic_mode_t;
	typedef struct packed {
		logic                 brake;
		logic [HIC_AMP_W-1:0] mag;
	} hic_drive_t;
endpackage
`default_nettype wire

// ==== rtl/hic_amp_map.sv ====
// input amplitude to drive magnitude and direction mapping
`default_nettype none
module hic_amp_map
	import hic_pkg::*;
#(
	parameter int W = HIC_AMP_W
) (
	input  wire logic      [W-1:0] amp,        // input amplitude, all ones is 100%
	input  wire hic_mode_t         mode,       // coding and loop mode
	input  wire logic              fb_brake,   // feedback asks for braking
	output var  hic_drive_t        drive       // mapped drive
);
	initial begin
		if (W != HIC_AMP_W) $error("hic_amp_map: W must equal HIC_AMP_W");
	end

	localparam logic [W-1:0] HALF = {1'b1, {(W-1){1'b0}}};
	localparam logic [W-1:0] FULL = {W{1'b1}};

	// doubles the distance from mid-scale, saturating at full scale
	function automatic logic [W-1:0] dbl_sat(input logic [W-1:0] d);
		logic [W:0] s;
		s = {d, 1'b0};
		dbl_sat = s[W] ? FULL : s[W-1:0];
	endfunction

	wire logic         above   = amp > HALF;
	wire logic [W-1:0] up_dist = amp - HALF;
	wire logic [W-1:0] dn_dist = HALF - amp;
	wire logic [W-1:0] up_mag  = (amp == FULL) ? FULL : dbl_sat(up_dist);

	always_comb begin
		case (mode)
			HIC_MODE_UNI: begin
				drive.mag   = amp;
				drive.brake = fb_brake;
			end
			HIC_MODE_BIOPEN: begin
				drive.mag   = above ? up_mag : dbl_sat(dn_dist);
				drive.brake = amp < HALF;
			end
			HIC_MODE_BICLO: begin
				drive.mag   = above ? up_mag : '0;
				drive.brake = fb_brake;
			end
			default: begin
				drive.mag   = '0;
				drive.brake = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ==== rtl/hic_sample_timer.sv ====
// auto-resonance sampling period tick generator
`default_nettype none
module hic_sample_timer
	import hic_pkg::*;
#(
	parameter int CYC0 = HIC_SAMP0_CYC,
	parameter int CYC1 = HIC_SAMP1_CYC,
	parameter int CYC2 = HIC_SAMP2_CYC,
	parameter int CYC3 = HIC_SAMP3_CYC
) (
	input  wire logic       clk,      // clock
	input  wire logic       rst,      // sync reset
	input  wire logic [1:0] sel,      // sampling period code
	output var  logic       tick_q    // one-cycle pulse per period
);
	initial begin
		if (CYC0 < 2 || CYC1 < 2 || CYC2 < 2 || CYC3 < 2 ||
		    CYC0 >= 2**HIC_CNT_W || CYC1 >= 2**HIC_CNT_W ||
		    CYC2 >= 2**HIC_CNT_W || CYC3 >= 2**HIC_CNT_W)
			$error("hic_sample_timer: period counts out of range");
	end

	logic [HIC_CNT_W-1:0] cnt_q;
	logic [HIC_CNT_W-1:0] last;

	always_comb begin
		case (sel)
			2'h0:    last = HIC_CNT_W'(CYC0 - 1);
			2'h1:    last = HIC_CNT_W'(CYC1 - 1);
			2'h2:    last = HIC_CNT_W'(CYC2 - 1);
			default: last = HIC_CNT_W'(CYC3 - 1);
		endcase
	end

	// >= so a shorter period chosen mid-count ends at once
	wire logic wrap = cnt_q >= last;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
			tick_q <= wrap;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/hic_ctrl.sv ====
// haptic input interpretation control: register, amplitude mapping, gain and sampling
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`default_nettype none
module hic_ctrl
	import hic_pkg::*;
#(
	parameter int SAMP0_CYC = HIC_SAMP0_CYC,
	parameter int SAMP1_CYC = HIC_SAMP1_CYC,
	parameter int SAMP2_CYC = HIC_SAMP2_CYC,
	parameter int SAMP3_CYC = HIC_SAMP3_CYC
) (
	input  wire logic                 clk,             // clock, 125 MHz
	input  wire logic                 rst,             // sync reset, active high
	input  wire logic [7:0]           reg_addr,        // register address
	input  wire logic [7:0]           reg_wdata,       // write data
	input  wire logic                 reg_we,          // write strobe
	input  wire logic                 reg_re,          // read strobe
	output var  logic [7:0]           reg_rdata_q,     // read data, cycle after strobe
	input  wire logic [HIC_AMP_W-1:0] amp_in,          // input amplitude
	input  wire logic                 amp_valid,       // amplitude sample strobe
	input  wire logic                 closed_loop,     // closed-loop drive active
	input  wire logic                 fb_brake,        // feedback asks for braking
	input  wire logic                 brake_near_done, // braking almost complete
	output var  hic_drive_t           drive_q,         // drive magnitude and brake
	output var  logic                 drive_valid_q,   // drive updated pulse
	output var  logic                 gain_reduce_q,   // lower loop gain
	output var  logic                 sample_tick_q,   // resonance sampling tick
	output var  logic [1:0]           sample_sel_q     // active sampling period code
);
	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;

	wire logic ctrl_hit = reg_addr == HIC_CTRL_ADDR;
	wire logic stat_hit = reg_addr == HIC_STAT_ADDR;
	wire logic bidir    = ctrl_q[HIC_BIDIR_BIT];
	wire logic stab_en  = ctrl_q[HIC_STAB_BIT];
	wire logic [1:0] samp_code = ctrl_q[HIC_SAMP_LSB +: 2];

	assign ctrl_d = (reg_we && ctrl_hit) ? reg_wdata : ctrl_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= HIC_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// amplitude mapping
	// ----------------------------------------------------------------
	hic_mode_t  mode;
	hic_drive_t drive_d;

	// the host is expected to avoid unidirectional coding in open loop;
	// if it does not, the input is still read as unidirectional
	assign mode = !bidir      ? HIC_MODE_UNI :
	              closed_loop ? HIC_MODE_BICLO : HIC_MODE_BIOPEN;

	hic_amp_map #(
		.W (HIC_AMP_W)
	) u_map (
		.amp      (amp_in),
		.mode     (mode),
		.fb_brake (fb_brake),
		.drive    (drive_d)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			drive_q       <= '0;
			drive_valid_q <= 1'b0;
		end else begin
			if (amp_valid) begin
				drive_q <= drive_d;
			end
			drive_valid_q <= amp_valid;
		end
	end

	// ----------------------------------------------------------------
	// brake end gain reduction
	// ----------------------------------------------------------------
	wire logic gain_reduce_d = stab_en && drive_q.brake && brake_near_done;

	always_ff @(posedge clk) begin
		if (rst) begin
			gain_reduce_q <= 1'b0;
			sample_sel_q  <= 2'h0;
		end else begin
			gain_reduce_q <= gain_reduce_d;
			sample_sel_q  <= samp_code;
		end
	end

	// ----------------------------------------------------------------
	// resonance sampling timer
	// ----------------------------------------------------------------
	hic_sample_timer #(
		.CYC0 (SAMP0_CYC),
		.CYC1 (SAMP1_CYC),
		.CYC2 (SAMP2_CYC),
		.CYC3 (SAMP3_CYC)
	) u_timer (
		.clk    (clk),
		.rst    (rst),
		.sel    (samp_code),
		.tick_q (sample_tick_q)
	);

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	wire logic [7:0] stat_val = {5'h00, closed_loop, gain_reduce_q, drive_q.brake};
	wire logic [7:0] rdata_d  = !reg_re  ? 8'h00 :
	                            ctrl_hit ? ctrl_q :
	                            stat_hit ? stat_val : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// check helpers
	// ----------------------------------------------------------------
	// cycles since the last tick; a code change spoils the gap until the next tick
	logic [HIC_CNT_W-1:0] tick_gap_q;
	logic                 sel_moved_q;

	function automatic logic [HIC_CNT_W-1:0] period_last(input logic [1:0] code);
		case (code)
			2'h0:    period_last = HIC_CNT_W'(SAMP0_CYC - 1);
			2'h1:    period_last = HIC_CNT_W'(SAMP1_CYC - 1);
			2'h2:    period_last = HIC_CNT_W'(SAMP2_CYC - 1);
			default: period_last = HIC_CNT_W'(SAMP3_CYC - 1);
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (rst || sample_tick_q) begin
			tick_gap_q  <= '0;
			sel_moved_q <= 1'b0;
		end else begin
			tick_gap_q  <= (tick_gap_q == '1) ? tick_gap_q : tick_gap_q + 1'b1;
			sel_moved_q <= sel_moved_q || (samp_code != sample_sel_q);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	localparam logic [HIC_AMP_W-1:0] A_HALF = 8'h80;
	localparam logic [HIC_AMP_W-1:0] A_QTR  = 8'h40;
	localparam logic [HIC_AMP_W-1:0] A_3QTR = 8'hC0;
	localparam logic [HIC_AMP_W-1:0] A_FULL = 8'hFF;

	sequence s_uni_sample;
		amp_valid && !bidir;
	endsequence

	sequence s_open_sample;
		amp_valid && bidir && !closed_loop;
	endsequence

	sequence s_closed_sample;
		amp_valid && bidir && closed_loop;
	endsequence

	sequence s_open_lower;
		s_open_sample ##0 (amp_in != 8'h00 && amp_in <= A_HALF);
	endsequence

	sequence s_bidir_upper;
		amp_valid && bidir && amp_in > A_HALF && amp_in != A_FULL;
	endsequence

	sequence s_clean_tick;
		sample_tick_q && !sel_moved_q;
	endsequence

	reset_value_a: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> (ctrl_q[HIC_BIDIR_BIT] && ctrl_q[HIC_STAB_BIT] &&
		               ctrl_q[HIC_SAMP_LSB +: 2] == 2'h1))
		else $error("control register reset value wrong");

	uni_passthrough_a: assert property (@(posedge clk) disable iff (rst)
		s_uni_sample |=> drive_q.mag == $past(amp_in) && drive_valid_q)
		else $error("unidirectional magnitude not equal to input");

	uni_brake_fb_a: assert property (@(posedge clk) disable iff (rst)
		s_uni_sample |=> drive_q.brake == $past(fb_brake))
		else $error("unidirectional brake not from feedback");

	open_brake_low_a: assert property (@(posedge clk) disable iff (rst)
		s_open_sample |=> drive_q.brake == ($past(amp_in) < A_HALF))
		else $error("open-loop brake not tied to lower half");

	open_points_a: assert property (@(posedge clk) disable iff (rst)
		s_open_sample ##0 (amp_in == A_HALF || amp_in == A_QTR || amp_in == A_3QTR)
		|=> drive_q.mag == (($past(amp_in) == A_HALF) ? 8'h00 : 8'h80))
		else $error("open-loop example point magnitude wrong");

	closed_zero_a: assert property (@(posedge clk) disable iff (rst)
		amp_valid && bidir && closed_loop && amp_in <= A_HALF |=> drive_q.mag == 8'h00)
		else $error("closed-loop lower half not silent");

	closed_full_a: assert property (@(posedge clk) disable iff (rst)
		amp_valid && bidir && closed_loop && amp_in == A_FULL |=> drive_q.mag == A_FULL)
		else $error("closed-loop full input not full scale");

	gain_reduce_a: assert property (@(posedge clk) disable iff (rst)
		gain_reduce_q |-> $past(stab_en) && $past(drive_q.brake) && $past(brake_near_done))
		else $error("gain reduced without brake ending");

	tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
		sample_tick_q |=> !sample_tick_q)
		else $error("sampling tick longer than one cycle");

	tick_period_a: assert property (@(posedge clk) disable iff (rst)
		s_clean_tick |-> tick_gap_q == period_last(sample_sel_q))
		else $error("sampling period does not match its code");

	ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_re && ctrl_hit |=> reg_rdata_q == $past(ctrl_q))
		else $error("control register read back wrong");

	gain_set_a: assert property (@(posedge clk) disable iff (rst)
		stab_en && drive_q.brake && brake_near_done |=> gain_reduce_q)
		else $error("gain not reduced at brake end");

	open_full_a: assert property (@(posedge clk) disable iff (rst)
		s_open_sample ##0 (amp_in == 8'h00 || amp_in == A_FULL) |=> drive_q.mag == A_FULL)
		else $error("open-loop end point not full scale");

	open_upper_drive_a: assert property (@(posedge clk) disable iff (rst)
		s_open_sample ##0 (amp_in > A_HALF) |=> !drive_q.brake)
		else $error("open-loop upper half braking");

	open_lower_line_a: assert property (@(posedge clk) disable iff (rst)
		s_open_lower |=> {1'b0, drive_q.mag} == 9'h100 - {$past(amp_in), 1'b0})
		else $error("open-loop lower half not linear");

	bidir_upper_line_a: assert property (@(posedge clk) disable iff (rst)
		s_bidir_upper |=> {1'b0, drive_q.mag} == {$past(amp_in), 1'b0} - 9'h100)
		else $error("bidirectional upper half not linear");

	closed_brake_fb_a: assert property (@(posedge clk) disable iff (rst)
		s_closed_sample |=> drive_q.brake == $past(fb_brake))
		else $error("closed-loop brake not from feedback");

	closed_half_a: assert property (@(posedge clk) disable iff (rst)
		s_closed_sample ##0 (amp_in == A_3QTR) |=> drive_q.mag == 8'h80)
		else $error("closed-loop three quarter input not half scale");

	uni_half_a: assert property (@(posedge clk) disable iff (rst)
		s_uni_sample ##0 (amp_in == A_HALF) |=> drive_q.mag == A_HALF)
		else $error("unidirectional half input not half scale");

	ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
		reg_we && ctrl_hit |=> ctrl_q == $past(reg_wdata))
		else $error("control register write lost");

	write_ignored_a: assert property (@(posedge clk) disable iff (rst)
		!(reg_we && ctrl_hit) |=> ctrl_q == $past(ctrl_q))
		else $error("control register changed without a write");

	stat_read_a: assert property (@(posedge clk) disable iff (rst)
		reg_re && stat_hit |=> reg_rdata_q[HIC_STAT_BRAKE] == $past(drive_q.brake) &&
		reg_rdata_q[HIC_STAT_GAIN] == $past(gain_reduce_q) &&
		reg_rdata_q[HIC_STAT_CLOSE] == $past(closed_loop))
		else $error("status register read back wrong");

	read_idle_a: assert property (@(posedge clk) disable iff (rst)
		!reg_re |=> reg_rdata_q == 8'h00)
		else $error("read data outside the read cycle");

	valid_pulse_a: assert property (@(posedge clk) disable iff (rst)
		drive_valid_q == $past(amp_valid))
		else $error("drive valid not one cycle after sample");

	drive_hold_a: assert property (@(posedge clk) disable iff (rst)
		!amp_valid |=> drive_q == $past(drive_q))
		else $error("drive changed without a sample");

	reset_outputs_a: assert property (@(posedge clk) disable iff (rst)
		$past(rst) |-> drive_q == '0 && !drive_valid_q && !gain_reduce_q &&
		               reg_rdata_q == 8'h00 && !sample_tick_q)
		else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ==== dv/hic_act_model.sv ====
// behavioural actuator: braking feedback follows the scenario command, near-done answers the drive
`default_nettype none
module hic_act_model
	import hic_pkg::*;
(
	input  wire logic       clk,       // clock
	input  wire logic       rst,       // sync reset
	input  wire hic_drive_t drive,     // drive from the block
	input  wire logic       brake_cmd, // scenario asks the loop to brake
	output var  logic       fb_brake,  // feedback says brake
	output var  logic       near_done  // braking almost over
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] speed_q;
	assign fb_brake  = brake_cmd;
	assign near_done = drive.brake && (speed_q < 4'h2);
	// speed builds under forward drive and decays under braking
	always_ff @(posedge clk) begin
		if (rst)
			speed_q <= 4'h0;
		else if (drive.brake && speed_q != 4'h0)
			speed_q <= speed_q - 4'h1;
		else if (!drive.brake && drive.mag != 8'h00 && speed_q != 4'hF)
			speed_q <= speed_q + 4'h1;
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the input interpretation control block
`default_nettype none
module testbench
	import hic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int C0 = 20;
	localparam int C1 = 30;
	localparam int C2 = 40;
	localparam int C3 = 50;
	int         cyc [4] = '{C0, C1, C2, C3};
	logic       clk = 0, rst = 1, we = 0, re = 0, av = 0, cl = 0, bcmd = 0;
	logic [7:0] addr = 0, wdata = 0, amp_in = 0, rdata;
	hic_drive_t drive;
	logic       dv, gain, tick, fb, nd;
	logic [1:0] ssel;
	int         mismatches = 0, num_checks = 0, k;
	always #4 clk = ~clk;
	hic_ctrl #(.SAMP0_CYC(C0), .SAMP1_CYC(C1), .SAMP2_CYC(C2), .SAMP3_CYC(C3)) hic_ctrl_inst (
		.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we),
		.reg_re(re), .reg_rdata_q(rdata), .amp_in(amp_in), .amp_valid(av),
		.closed_loop(cl), .fb_brake(fb), .brake_near_done(nd), .drive_q(drive),
		.drive_valid_q(dv), .gain_reduce_q(gain), .sample_tick_q(tick),
		.sample_sel_q(ssel));
	hic_act_model hic_act_model_inst (.clk(clk), .rst(rst), .drive(drive),
		.brake_cmd(bcmd), .fb_brake(fb), .near_done(nd));
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 chk({1'b0, rdata}, {1'b0, exp});
	endtask
	task automatic amp(input logic [7:0] a, input logic [8:0] exp);
		@(posedge clk);
		av <= 1'b1;
		amp_in <= a;
		@(posedge clk);
		av <= 1'b0;
		#1 chk(drive, exp);
		chk({8'h00, dv}, 9'h001);
	endtask
	task automatic next_tick();
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while (tick !== 1'b1 && k < 100);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(HIC_CTRL_ADDR, 8'hDA);
		@(posedge clk);
		#1 chk({1'b0, rdata}, 9'h000);
		chk({7'h00, ssel}, 9'h001);
		wr(8'h55, 8'h00);
		wr(HIC_STAT_ADDR, 8'h00);
		rd(8'h30, 8'h00);
		rd(HIC_STAT_ADDR, 8'h00);
		rd(HIC_CTRL_ADDR, 8'hDA);
		$display("register test done");
		amp(8'h00, 9'h1FF);
		@(posedge clk);
		#1 chk({8'h00, gain}, 9'h001);
		amp(8'h40, 9'h180);
		amp(8'h60, 9'h140);
		amp(8'h80, 9'h000);
		amp(8'hC0, 9'h080);
		amp(8'hFF, 9'h0FF);
		repeat (20) @(posedge clk);
		amp(8'h00, 9'h1FF);
		@(posedge clk);
		#1 chk({8'h00, gain}, 9'h000);
		k = 0;
		while (gain !== 1'b1 && k < 30) begin
			@(posedge clk);
			#1 k++;
		end
		chk({8'h00, gain}, 9'h001);
		wr(HIC_CTRL_ADDR, 8'h9A);
		@(posedge clk);
		#1 chk({8'h00, gain}, 9'h000);
		wr(HIC_CTRL_ADDR, 8'hDA);
		$display("open loop test done");
		@(posedge clk);
		cl <= 1'b1;
		bcmd <= 1'b1;
		amp(8'h00, 9'h100);
		rd(HIC_STAT_ADDR, 8'h07);
		amp(8'h80, 9'h100);
		amp(8'hC0, 9'h180);
		amp(8'hFF, 9'h1FF);
		bcmd <= 1'b0;
		amp(8'hC0, 9'h080);
		wr(HIC_CTRL_ADDR, 8'h5A);
		amp(8'h00, 9'h000);
		amp(8'h80, 9'h080);
		amp(8'h81, 9'h081);
		amp(8'hFF, 9'h0FF);
		bcmd <= 1'b1;
		amp(8'h40, 9'h140);
		$display("closed loop test done");
		for (int c = 0; c < 4; c++) begin
			wr(HIC_CTRL_ADDR, {2'b11, 2'(c), 4'hA});
			next_tick();
			next_tick();
			chk(9'(k), 9'(cyc[c]));
			chk({7'h00, ssel}, 9'(c));
		end
		$display("sampling test done");
		complete_run();
	end
endmodule
`default_nettype wire
